/* File: core/ppcb_bank.sv */
// Pin configuration bank: register file and per-pin pad controls for ports 0 to 3.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps
module ppcb_bank
  import ppcb_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Register port.
  input wire logic [ppcb_pkg::ppcb_addr_w-1:0] addr,
  input wire logic [ppcb_pkg::ppcb_data_w-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [ppcb_pkg::ppcb_data_w-1:0] rdata,
  // Port 1 controls toward the routing and pads.
  output logic [63:0] port1_pin_function_select,
  output logic [31:0] port1_pin_pullup_on,
  output logic [31:0] port1_pin_opendrain_on,
  // Port 2 controls.
  output logic [55:0] port2_pin_function_select,
  output logic [27:0] port2_pin_pullup_on,
  output logic [27:0] port2_pin_opendrain_on,
  // Port 3 controls.
  output logic [19:0] port3_pin_function_select,
  output logic [9:0] port3_pin_pullup_on,
  // Port 0 open-drain control.
  output logic [31:0] port0_pin_opendrain_on,
  // Pad drive from the selected function, ports 0 to 2 (96 pins, port 0 low).
  input wire logic [95:0] pad_out_data,
  input wire logic [95:0] pad_out_enable,
  output logic [95:0] pad_drive_value,
  output logic [95:0] pad_drive_enable,
  // Per-pin alternate function flag for ports 1 and 2 (port 1 low).
  output logic [59:0] pin_alt_selected
);
  import ppcb_pkg::*;

  // Register values in a fixed order.
  logic [31:0] p0_od;
  logic [31:0] p1_ml;
  logic [31:0] p1_mh;
  logic [31:0] p1_pu;
  logic [31:0] p1_od;
  logic [31:0] p2_ml;
  logic [31:0] p2_mh;
  logic [31:0] p2_pu;
  logic [31:0] p2_od;
  logic [31:0] p3_ml;
  logic [31:0] p3_pu;

  // Address decode, one strobe per register.
  wire hit_p0_od = (addr == ppcb_p0_od_off);
  wire hit_p1_ml = (addr == ppcb_p1_ml_off);
  wire hit_p1_mh = (addr == ppcb_p1_mh_off);
  wire hit_p1_pu = (addr == ppcb_p1_pu_off);
  wire hit_p1_od = (addr == ppcb_p1_od_off);
  wire hit_p2_ml = (addr == ppcb_p2_ml_off);
  wire hit_p2_mh = (addr == ppcb_p2_mh_off);
  wire hit_p2_pu = (addr == ppcb_p2_pu_off);
  wire hit_p2_od = (addr == ppcb_p2_od_off);
  wire hit_p3_ml = (addr == ppcb_p3_ml_off);
  wire hit_p3_pu = (addr == ppcb_p3_pu_off);

  // Port 0 open-drain register.
  ppcb_cfg_reg #(.RESET_VALUE(ppcb_zero_rst), .WRITE_MASK(ppcb_full_mask)) u_p0_od (
    .clk(clk), .rst_n(rst_n), .wr_en(wr && hit_p0_od), .wr_data(wdata), .value(p0_od));

  // Port 1 registers, all 32 bits writable.
  ppcb_cfg_reg #(.RESET_VALUE(ppcb_zero_rst), .WRITE_MASK(ppcb_full_mask)) u_p1_ml (
    .clk(clk), .rst_n(rst_n), .wr_en(wr && hit_p1_ml), .wr_data(wdata), .value(p1_ml));
  ppcb_cfg_reg #(.RESET_VALUE(ppcb_zero_rst), .WRITE_MASK(ppcb_full_mask)) u_p1_mh (
    .clk(clk), .rst_n(rst_n), .wr_en(wr && hit_p1_mh), .wr_data(wdata), .value(p1_mh));
  ppcb_cfg_reg #(.RESET_VALUE(ppcb_zero_rst), .WRITE_MASK(ppcb_full_mask)) u_p1_pu (
    .clk(clk), .rst_n(rst_n), .wr_en(wr && hit_p1_pu), .wr_data(wdata), .value(p1_pu));
  ppcb_cfg_reg #(.RESET_VALUE(ppcb_zero_rst), .WRITE_MASK(ppcb_full_mask)) u_p1_od (
    .clk(clk), .rst_n(rst_n), .wr_en(wr && hit_p1_od), .wr_data(wdata), .value(p1_od));

  // Port 2 registers, upper pins reserved.
  ppcb_cfg_reg #(.RESET_VALUE(ppcb_zero_rst), .WRITE_MASK(ppcb_full_mask)) u_p2_ml (
    .clk(clk), .rst_n(rst_n), .wr_en(wr && hit_p2_ml), .wr_data(wdata), .value(p2_ml));
  ppcb_cfg_reg #(.RESET_VALUE(ppcb_zero_rst), .WRITE_MASK(ppcb_p2_mh_mask)) u_p2_mh (
    .clk(clk), .rst_n(rst_n), .wr_en(wr && hit_p2_mh), .wr_data(wdata), .value(p2_mh));
  ppcb_cfg_reg #(.RESET_VALUE(ppcb_zero_rst), .WRITE_MASK(ppcb_p2_pin_mask)) u_p2_pu (
    .clk(clk), .rst_n(rst_n), .wr_en(wr && hit_p2_pu), .wr_data(wdata), .value(p2_pu));
  ppcb_cfg_reg #(.RESET_VALUE(ppcb_zero_rst), .WRITE_MASK(ppcb_p2_pin_mask)) u_p2_od (
    .clk(clk), .rst_n(rst_n), .wr_en(wr && hit_p2_od), .wr_data(wdata), .value(p2_od));

  // Port 3 registers with debug-friendly reset values.
  ppcb_cfg_reg #(.RESET_VALUE(ppcb_p3_ml_rst), .WRITE_MASK(ppcb_p3_ml_mask)) u_p3_ml (
    .clk(clk), .rst_n(rst_n), .wr_en(wr && hit_p3_ml), .wr_data(wdata), .value(p3_ml));
  ppcb_cfg_reg #(.RESET_VALUE(ppcb_p3_pu_rst), .WRITE_MASK(ppcb_p3_pu_mask)) u_p3_pu (
    .clk(clk), .rst_n(rst_n), .wr_en(wr && hit_p3_pu), .wr_data(wdata), .value(p3_pu));

  // Read multiplexer; unmapped offsets return zero.
  logic [31:0] read_sel;
  assign read_sel = hit_p0_od ? p0_od :
                    hit_p1_ml ? p1_ml :
                    hit_p1_mh ? p1_mh :
                    hit_p1_pu ? p1_pu :
                    hit_p1_od ? p1_od :
                    hit_p2_ml ? p2_ml :
                    hit_p2_mh ? p2_mh :
                    hit_p2_pu ? p2_pu :
                    hit_p2_od ? p2_od :
                    hit_p3_ml ? p3_ml :
                    hit_p3_pu ? p3_pu : ppcb_zero_rst;

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= ppcb_zero_rst;
    end else if (rd) begin
      rdata <= read_sel;
    end else begin
      rdata <= ppcb_zero_rst;
    end
  end

  // Control fields toward the routing and pads.
  assign port1_pin_function_select = {p1_mh, p1_ml};
  assign port2_pin_function_select = {p2_mh[23:0], p2_ml};
  assign port3_pin_function_select = p3_ml[19:0];
  assign port1_pin_pullup_on = p1_pu;
  assign port2_pin_pullup_on = p2_pu[27:0];
  assign port3_pin_pullup_on = p3_pu[9:0];
  assign port0_pin_opendrain_on = p0_od;
  assign port1_pin_opendrain_on = p1_od;
  assign port2_pin_opendrain_on = p2_od[27:0];

  // Open-drain flags for all 96 pads; port 2 top pins never open-drain.
  logic [95:0] od_all;
  assign od_all = {4'h0, p2_od[27:0], p1_od, p0_od};

  // Per-pin pad drive; open-drain pins only pull low and release otherwise.
  genvar gi;
  generate
    for (gi = 0; gi < 96; gi++) begin : g_pad
      assign pad_drive_value[gi] = od_all[gi] ? 1'b0 : pad_out_data[gi];
      assign pad_drive_enable[gi] = pad_out_enable[gi] &
                                    (~od_all[gi] | ~pad_out_data[gi]);
    end
    // Alternate function flag from the two-bit selector.
    for (gi = 0; gi < 60; gi++) begin : g_alt
      if (gi < 32) begin : g_p1
        assign pin_alt_selected[gi] =
          (port1_pin_function_select[2*gi +: 2] != ppcb_fn_gpio);
      end else begin : g_p2
        assign pin_alt_selected[gi] =
          (port2_pin_function_select[2*(gi-32) +: 2] != ppcb_fn_gpio);
      end
    end
  endgenerate

  // Checks on the register behaviour and the open-drain pad drive.
  a_reserved_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (p2_mh[31:24] == 8'h00) && (p2_pu[31:28] == 4'h0) && (p2_od[31:28] == 4'h0) &&
    (p3_ml[31:20] == 12'h000) && (p3_pu[31:10] == 22'h000000))
    else $error("reserved bits set");
  a_p3_reset_vals: assert property (@(posedge clk)
    $rose(rst_n) |-> (p3_ml == ppcb_p3_ml_rst) && (p3_pu == ppcb_p3_pu_rst))
    else $error("port 3 reset value wrong");
  a_p1pu_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && hit_p1_pu |=> port1_pin_pullup_on == $past(wdata))
    else $error("port 1 pull-up write lost");
  a_p2od_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && hit_p2_od |=> port2_pin_opendrain_on == $past(wdata[27:0]))
    else $error("port 2 open-drain write lost");
  a_p0od_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && hit_p0_od |=> port0_pin_opendrain_on == $past(wdata))
    else $error("port 0 open-drain write lost");
  a_od_no_high: assert property (@(posedge clk) disable iff (!rst_n)
    (pad_drive_enable & od_all & pad_out_data) == 96'h0)
    else $error("open-drain pad driven high");
  a_od_drives_low: assert property (@(posedge clk) disable iff (!rst_n)
    (pad_drive_enable & od_all) == (pad_out_enable & od_all & ~pad_out_data))
    else $error("open-drain pad not pulled low");
  a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
    rd && (addr == 8'h34) |=> rdata == 32'h0)
    else $error("unmapped offset read not zero");
  sequence s_write_p1od;
    wr && hit_p1_od;
  endsequence
  a_read_back: assert property (@(posedge clk) disable iff (!rst_n)
    s_write_p1od ##1 (rd && hit_p1_od && !wr) |=> rdata == $past(wdata, 2))
    else $error("port 1 open-drain read back wrong");
  a_p2mh_write: assert property (@(posedge clk) disable iff (!rst_n)
    wr && hit_p2_mh |=> p2_mh == {8'h00, $past(wdata[23:0])})
    else $error("port 2 mode high write wrong");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !rd |=> rdata == 32'h0)
    else $error("read data outside read slot");
endmodule : ppcb_bank

/* File: core/ppcb_pkg.sv */
// Package with register map, field widths and reset values of the pin configuration bank.
//
// Functional notes
// - Two-bit selector: 00 GPIO, else alternate.
// - Mode low/high pack two bits per pin.
// - Port 2 mode high uses bits 23:0.
// - Port 3 mode bits 19:0, reset 0x55400.
// - Pull-up bit per pin, port 1 resets zero.
// - Port 2 pull-up uses bits 27:0.
// - Port 1 open-drain bit per pin, reset zero.
// - Open-drain pins drive low only, release high.
// - Port 0 open-drain 32 bits, reset zero.
// - Port 2 open-drain bits 27:0, reset zero.
// - Port 3 pull-up resets to 0x3A0.
// - Sixteen-byte group per port, fixed offsets.
package ppcb_pkg;
  localparam int unsigned ppcb_addr_w = 8;
  localparam int unsigned ppcb_data_w = 32;
  // Register byte offsets.
  localparam logic [7:0] ppcb_p0_od_off = 8'h0C;
  localparam logic [7:0] ppcb_p1_ml_off = 8'h10;
  localparam logic [7:0] ppcb_p1_mh_off = 8'h14;
  localparam logic [7:0] ppcb_p1_pu_off = 8'h18;
  localparam logic [7:0] ppcb_p1_od_off = 8'h1C;
  localparam logic [7:0] ppcb_p2_ml_off = 8'h20;
  localparam logic [7:0] ppcb_p2_mh_off = 8'h24;
  localparam logic [7:0] ppcb_p2_pu_off = 8'h28;
  localparam logic [7:0] ppcb_p2_od_off = 8'h2C;
  localparam logic [7:0] ppcb_p3_ml_off = 8'h30;
  localparam logic [7:0] ppcb_p3_pu_off = 8'h38;
  // Writable bit masks; zero bits are reserved.
  localparam logic [31:0] ppcb_full_mask = 32'hFFFFFFFF;
  localparam logic [31:0] ppcb_p2_mh_mask = 32'h00FFFFFF;
  localparam logic [31:0] ppcb_p2_pin_mask = 32'h0FFFFFFF;
  localparam logic [31:0] ppcb_p3_ml_mask = 32'h000FFFFF;
  localparam logic [31:0] ppcb_p3_pu_mask = 32'h000003FF;
  // Reset values.
  localparam logic [31:0] ppcb_zero_rst = 32'h00000000;
  localparam logic [31:0] ppcb_p3_ml_rst = 32'h00055400;
  localparam logic [31:0] ppcb_p3_pu_rst = 32'h000003A0;
  // Function selector codes.
  typedef enum logic [1:0] {
    ppcb_fn_gpio = 2'h0,
    ppcb_fn_alt1 = 2'h1,
    ppcb_fn_alt2 = 2'h2,
    ppcb_fn_alt3 = 2'h3
  } ppcb_fsel_t;
  localparam int unsigned ppcb_pins = 32;
endpackage : ppcb_pkg

/* File: core/ppcb_cfg_reg.sv */
// One masked configuration register with reset value and write strobe.
`timescale 1ns/100ps
module ppcb_cfg_reg #(
  parameter logic [31:0] RESET_VALUE = 32'h00000000,
  parameter logic [31:0] WRITE_MASK = 32'hFFFFFFFF
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Write side.
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  // Stored value.
  output logic [31:0] value
);
  // A reset value with reserved bits set could never be written back, so it is refused.
  if ((RESET_VALUE & ~WRITE_MASK) != 32'h00000000) begin : g_bad_reset
    $error("reset value sets reserved bits");
  end

  // Register updates only on its own strobe.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= RESET_VALUE;
    end else if (wr_en) begin
      value <= wr_data & WRITE_MASK;
    end
  end
endmodule : ppcb_cfg_reg

/* File: tb/ppcb_pad_model.sv */
// Behavioural pad ring that resolves each pad level from the bank's drive signals.
`timescale 1ns/100ps
module ppcb_pad_model (
  // Clock.
  input wire logic clk,
  // Drive from the bank and pull state per pin.
  input wire logic [95:0] drv_value,
  input wire logic [95:0] drv_enable,
  input wire logic [95:0] pulled,
  // Resolved pad level.
  output logic [95:0] level
);
  logic [95:0] last;

  // Remember the level so an undriven, unpulled pad can drift.
  always_ff @(posedge clk) begin
    last <= level;
  end

  // A released pad is held high when pulled; otherwise it shows the inverse of the last level, so it can also rise unpulled.
  assign level = (drv_enable & drv_value) | (~drv_enable & (pulled | ~last));
endmodule : ppcb_pad_model

/* File: tb/port_pin_config_bank_tb.sv */
// Testbench for the pin configuration bank: register map, resets and pad drive.
`timescale 1ns/100ps
module port_pin_config_bank_tb;
  import ppcb_pkg::*;
  localparam logic [95:0] pd = {12{8'h5A}};
  localparam logic [95:0] pe = {12{8'hCC}};
  localparam logic [95:0] om = {4'h0, {92{1'b1}}};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [95:0] pad_data = '0;
  logic [95:0] pad_en = '0;
  logic [31:0] rdata, p1_pu, p1_od, p0_od;
  logic [63:0] p1_fs;
  logic [55:0] p2_fs;
  logic [27:0] p2_pu, p2_od;
  logic [19:0] p3_fs;
  logic [9:0] p3_pu;
  logic [95:0] dv, de, level;
  logic [59:0] alt;
  int mismatches = 0;
  int compares = 0;
  logic [7:0] ad [14] = '{8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C,
    8'h30, 8'h38, 8'h34, 8'h3C, 8'h00};
  logic [31:0] ex [14] = '{'1, '1, '1, '1, '1, '1, 32'h00FFFFFF, 32'h0FFFFFFF, 32'h0FFFFFFF,
    32'h000FFFFF, 32'h000003FF, '0, '0, '0};
  logic [31:0] rs [14] = '{'0, '0, '0, '0, '0, '0, '0, '0, '0, 32'h00055400, 32'h000003A0,
    '0, '0, '0};

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  // Design and pad ring.
  ppcb_bank ppcb_bank_i(.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .port1_pin_function_select(p1_fs), .port1_pin_pullup_on(p1_pu),
    .port1_pin_opendrain_on(p1_od), .port2_pin_function_select(p2_fs),
    .port2_pin_pullup_on(p2_pu), .port2_pin_opendrain_on(p2_od),
    .port3_pin_function_select(p3_fs), .port3_pin_pullup_on(p3_pu),
    .port0_pin_opendrain_on(p0_od), .pad_out_data(pad_data), .pad_out_enable(pad_en),
    .pad_drive_value(dv), .pad_drive_enable(de), .pin_alt_selected(alt));
  ppcb_pad_model ppcb_pad_model_i(.clk(clk), .drv_value(dv), .drv_enable(de),
    .pulled({4'h0, p2_pu | p2_od, p1_pu | p1_od, p0_od}), .level(level));

  // Compares one value and counts the outcome.
  task automatic chk(input string name, input logic [95:0] seen, input logic [95:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One-cycle register write.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg

  // One-cycle read; data is looked at in the following cycle.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", {64'h0, rdata}, {64'h0, e});
  endtask : rd_chk

  // Prints the verdict and ends the run.
  task automatic finish_test;
    if (mismatches == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test

  // Main sequence: reset values, masked read-back, outputs, pads, mid-run reset.
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 14; i++) rd_chk(ad[i], rs[i]);
    for (int i = 0; i < 14; i++) begin
      wr_reg(ad[i], 32'hA5A5A5A5);
      rd_chk(ad[i], 32'hA5A5A5A5 & ex[i]);
      wr_reg(ad[i], 32'hFFFFFFFF);
      rd_chk(ad[i], ex[i]);
    end
    wr_reg(8'h14, 32'h12345678);
    chk("p1 select", {32'h0, p1_fs}, {32'h0, 32'h12345678, 32'hFFFFFFFF});
    chk("p2 p3", {p2_fs[55:32], p2_pu, p3_fs, p3_pu}, {24'hFFFFFF, 28'hFFFFFFF, 20'hFFFFF, 10'h3FF});
    wr_reg(8'h10, 32'h000000E4);
    chk("alt", {alt[15:0], p1_fs[7:0]}, {16'h000E, 8'hE4});
    @(posedge clk);
    pad_data <= pd;
    pad_en <= pe;
    #2;
    chk("pad enable", de, pe & ~(om & pd));
    chk("pad value", dv, pd & ~om);
    chk("pad level", {4'h0, level[91:0]}, {4'h0, ~(pe[91:0] & ~pd[91:0])});
    wr_reg(8'h1C, 32'h00000000);
    chk("push pull", {32'h0, de[63:32], dv[63:32]}, {32'h0, pe[63:32], pd[63:32]});
    @(posedge clk);
    wr <= 1'b1;
    addr <= 8'h1C;
    wdata <= 32'h3C3C0F0F;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("back to back", {64'h0, rdata}, {64'h0, 32'h3C3C0F0F});
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("defaults", {p1_pu, p3_pu, p3_fs, p0_od}, {32'h0, 10'h3A0, 20'h55400, 32'h0});
    rd_chk(8'h30, 32'h00055400);
    finish_test();
  end

  // Cuts a hung run short.
  initial begin
    #200000;
    mismatches++;
    finish_test();
  end
endmodule : port_pin_config_bank_tb
